/* File: design/flash_host_pkg.sv */
/*
 * Constants and types for the parallel NOR flash host controller.
 * Assumes a 125 MHz clock and a x16 flash with 21 word address bits.
 */
package flash_host_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int CLK_NS = 8;
	// APB register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int OP_W = 4;
	localparam int ST_BUSY = 0;
	localparam int ST_READY = 1;
	localparam int ST_REFUSED = 2;
	// Flash command addresses and data
	localparam logic [20:0] UNLOCK1_ADDR = 21'h000555;
	localparam logic [20:0] UNLOCK2_ADDR = 21'h0002aa;
	localparam logic [20:0] QUERY_ADDR = 21'h000055;
	localparam logic [20:0] ANY_ADDR = 21'h000000;
	localparam logic [20:0] SECTOR_MASK = 21'h0ff000;
	localparam logic [7:0] KEY1 = 8'haa;
	localparam logic [7:0] KEY2 = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_SEC_ENTER = 8'h88;
	localparam logic [7:0] CMD_EXIT_TAIL = 8'h00;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_SECTOR = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	// Strobe timing: least times round up
	localparam int T_WP_NS = 35;
	localparam int T_ACC_NS = 70;
	localparam int SYNC_CYC = 2;
	localparam logic [3:0] WE_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RD_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
	typedef enum logic [3:0] {
		OP_READ, OP_RESET, OP_AUTOSEL, OP_QUERY, OP_SEC_ENTER, OP_SEC_EXIT,
		OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROGRAM, OP_BYP_EXIT, OP_CHIP_ERASE,
		OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME
	} op_t;
	typedef struct packed {
		logic rd;
		logic [20:0] addr;
		logic [15:0] data;
		logic last;
	} step_t;
endpackage : flash_host_pkg

/* File: design/flash_cycle_if.sv */
/*
 * Carrier between the command sequencer and the bus cycle engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface flash_cycle_if;
	logic start;
	logic is_read;
	logic [20:0] addr;
	logic [15:0] wdata;
	logic done;
	logic [15:0] rdata;
	modport seq (output start, output is_read, output addr, output wdata,
		input done, input rdata);
	modport eng (input start, input is_read, input addr, input wdata,
		output done, output rdata);
endinterface : flash_cycle_if

/* File: design/flash_cycle_engine.sv */
/*
 * Runs one flash bus cycle, write or read, on the strobe pins.
 * Assumes a request only arrives after the previous cycle is done.
 */
`timescale 1ns/10ps
module flash_cycle_engine (
	input wire logic clock,
	input wire logic resetn,
	flash_cycle_if.eng cyc,
	output logic [20:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe_n,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n
);
	import flash_host_pkg::*;
	typedef enum logic [2:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_DONE} eng_t;
	eng_t st_reg, st_next;
	logic rd_reg, rd_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [20:0] addr_reg, addr_next;
	logic [15:0] wd_reg, wd_next, rdata_reg, rdata_next;
	logic [15:0] dq_s1_reg, dq_s2_reg;

	always_comb begin
		st_next = st_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		wd_next = wd_reg;
		rdata_next = rdata_reg;
		case (st_reg)
			E_IDLE: if (cyc.start) begin
				st_next = E_SETUP;
				rd_next = cyc.is_read;
				addr_next = cyc.addr;
				wd_next = cyc.wdata;
			end
			// Chip select leads, so the write strobe fall latches the address
			E_SETUP: begin
				st_next = E_STROBE;
				cnt_next = rd_reg ? RD_CYC : WE_CYC;
			end
			E_STROBE: if (cnt_reg == 4'h1) begin
				st_next = E_HOLD;
				if (rd_reg)
					rdata_next = dq_s2_reg;
			end else begin
				cnt_next = cnt_reg - 4'h1;
			end
			// Data stays driven past the write strobe rise
			E_HOLD: st_next = E_DONE;
			default: st_next = E_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_reg <= E_IDLE;
			rd_reg <= 1'b0;
			cnt_reg <= 4'h0;
			addr_reg <= 21'h000000;
			wd_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
			dq_s1_reg <= 16'h0000;
			dq_s2_reg <= 16'h0000;
		end else begin
			st_reg <= st_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			wd_reg <= wd_next;
			rdata_reg <= rdata_next;
			dq_s1_reg <= flash_dq_in;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	assign flash_addr = addr_reg;
	assign flash_dq_out = wd_reg;
	assign flash_ce_n = !(st_reg == E_SETUP || st_reg == E_STROBE || st_reg == E_HOLD);
	assign flash_we_n = !(st_reg == E_STROBE && !rd_reg);
	assign flash_oe_n = !(st_reg == E_STROBE && rd_reg);
	// Bus released during reads so the flash can drive it
	assign flash_dq_oe_n = !(st_reg != E_IDLE && !rd_reg);
	assign cyc.done = st_reg == E_DONE;
	assign cyc.rdata = rdata_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence we_fall_s;
		$fell(flash_we_n);
	endsequence
	we_under_ce_a: assert property (!flash_we_n |-> !flash_ce_n && $past(!flash_ce_n))
		else $error("write strobe fell without chip select leading");
	we_width_a: assert property (we_fall_s |-> !flash_we_n [*5] ##1 flash_we_n)
		else $error("write strobe width wrong");
	data_hold_a: assert property ($rose(flash_we_n) |-> !flash_dq_oe_n && !flash_ce_n)
		else $error("write data released at strobe rise");
	no_clash_a: assert property (!(!flash_oe_n && !flash_dq_oe_n))
		else $error("bus driven during read");
endmodule : flash_cycle_engine

/* File: design/flash_host_ctrl.sv */
/*
 * APB-programmed host that issues command sequences to a x16 NOR flash.
 * Assumes an APB master on the same clock and flash pins wired direct.
 */
// The APB slave port and the placing of the registers were left to the implementer.
// Operation
// - Autoselect is AA/555, 55/2AA, 90/555 then a read at offset.
// - Secured region entry ends 88/555; exit ends 90/555 then 00.
// - Word program is AA/555, 55/2AA, A0/555, then word at target.
// - Bypass entry ends 20/555 and precedes two-write programming.
// - Erase is six writes ending 10/555 chip or 30 at sector.
`timescale 1ns/10ps
module flash_host_ctrl (
	input wire logic clock,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
	output logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe_n,
	input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	input wire logic flash_ready_busy_n
);
	import flash_host_pkg::*;
	typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} seq_t;
	seq_t st_reg, st_next;
	op_t op_reg, op_next;
	logic [2:0] idx_reg, idx_next;
	logic [20:0] addr_reg, addr_next;
	logic [15:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic refused_reg, refused_next;
	logic rb_s1_reg, rb_s2_reg;
	logic wr_en, rd_en, mapped, ctrl_wr, op_ok;
	step_t step;
	flash_cycle_if cyc ();

	flash_cycle_engine u_engine (
		.clock(clock),
		.resetn(resetn),
		.cyc(cyc.eng),
		.flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe_n(flash_dq_oe_n),
		.flash_dq_in(flash_dq_in),
		.flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n),
		.flash_oe_n(flash_oe_n)
	);

	// Command bytes go out with the upper byte cleared
	function automatic step_t wr_step(input logic [20:0] a, input logic [7:0] d,
		input logic last);
		wr_step = '{rd: 1'b0, addr: a, data: {8'h00, d}, last: last};
	endfunction : wr_step

	// One entry per bus cycle of each sequence
	function automatic step_t step_f(input op_t op, input logic [2:0] i,
		input logic [20:0] a, input logic [15:0] w);
		step_t s;
		logic [7:0] tail;
		s = wr_step(ANY_ADDR, CMD_RESET, 1'b1);
		tail = CMD_AUTOSEL;
		case (op)
			OP_SEC_ENTER: tail = CMD_SEC_ENTER;
			OP_PROGRAM: tail = CMD_PROGRAM;
			OP_BYP_ENTER: tail = CMD_BYPASS;
			OP_CHIP_ERASE, OP_SECTOR_ERASE: tail = CMD_ERASE;
			default: tail = CMD_AUTOSEL;
		endcase
		case (op)
			OP_READ: s = '{rd: 1'b1, addr: a, data: 16'h0000, last: 1'b1};
			OP_RESET: s = wr_step(ANY_ADDR, CMD_RESET, 1'b1);
			OP_QUERY: s = wr_step(QUERY_ADDR, CMD_QUERY, 1'b1);
			OP_SUSPEND: s = wr_step(ANY_ADDR, CMD_SUSPEND, 1'b1);
			OP_RESUME: s = wr_step(ANY_ADDR, CMD_RESUME, 1'b1);
			OP_BYP_PROGRAM: begin
				if (i == 3'h0)
					s = wr_step(ANY_ADDR, CMD_PROGRAM, 1'b0);
				else
					s = '{rd: 1'b0, addr: a, data: w, last: 1'b1};
			end
			OP_BYP_EXIT: begin
				if (i == 3'h0)
					s = wr_step(ANY_ADDR, CMD_AUTOSEL, 1'b0);
				else
					s = wr_step(ANY_ADDR, CMD_EXIT_TAIL, 1'b1);
			end
			default: begin
				// Unlock prefix shared by all long sequences
				case (i)
					3'h0: s = wr_step(UNLOCK1_ADDR, KEY1, 1'b0);
					3'h1: s = wr_step(UNLOCK2_ADDR, KEY2, 1'b0);
					3'h2: s = wr_step(UNLOCK1_ADDR, tail,
						op == OP_SEC_ENTER || op == OP_BYP_ENTER);
					3'h3: begin
						if (op == OP_AUTOSEL)
							s = '{rd: 1'b1, addr: a, data: 16'h0000, last: 1'b1};
						else if (op == OP_SEC_EXIT)
							s = wr_step(ANY_ADDR, CMD_EXIT_TAIL, 1'b1);
						else if (op == OP_PROGRAM)
							s = '{rd: 1'b0, addr: a, data: w, last: 1'b1};
						else
							s = wr_step(UNLOCK1_ADDR, KEY1, 1'b0);
					end
					3'h4: s = wr_step(UNLOCK2_ADDR, KEY2, 1'b0);
					default: begin
						if (op == OP_SECTOR_ERASE)
							s = wr_step(a & SECTOR_MASK, CMD_SECTOR, 1'b1);
						else
							s = wr_step(UNLOCK1_ADDR, CMD_CHIP, 1'b1);
					end
				endcase
			end
		endcase
		return s;
	endfunction : step_f

	assign step = step_f(op_reg, idx_reg, addr_reg, wdata_reg);
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign ctrl_wr = wr_en && paddr == REG_CTRL;
	assign op_ok = pwdata[OP_W-1:0] <= OP_RESUME;
	assign pready = 1'b1;

	always_comb begin
		mapped = 1'b1;
		prdata = 32'h00000000;
		if (paddr == REG_CTRL) begin
			prdata = {28'h0000000, op_reg};
		end else if (paddr == REG_ADDR) begin
			prdata = {11'h000, addr_reg};
		end else if (paddr == REG_WDATA) begin
			prdata = {16'h0000, wdata_reg};
		end else if (paddr == REG_STATUS) begin
			// Ready/busy and read-back data carry the flash progress bits
			prdata[ST_BUSY] = st_reg != S_IDLE;
			prdata[ST_READY] = rb_s2_reg;
			prdata[ST_REFUSED] = refused_reg;
		end else if (paddr == REG_RDATA) begin
			prdata = {16'h0000, rdata_reg};
		end else begin
			mapped = 1'b0;
		end
		pslverr = psel && penable && !mapped;
	end

	always_comb begin
		st_next = st_reg;
		op_next = op_reg;
		idx_next = idx_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;
		refused_next = refused_reg;
		if (wr_en && paddr == REG_STATUS && pwdata[ST_REFUSED])
			refused_next = 1'b0;
		if (wr_en && paddr == REG_ADDR && st_reg == S_IDLE)
			addr_next = pwdata[ADDR_W-1:0];
		if (wr_en && paddr == REG_WDATA && st_reg == S_IDLE)
			wdata_next = pwdata[DATA_W-1:0];
		case (st_reg)
			S_IDLE: if (ctrl_wr) begin
				if (op_ok) begin
					op_next = op_t'(pwdata[OP_W-1:0]);
					idx_next = 3'h0;
					st_next = S_ISSUE;
				end else begin
					refused_next = 1'b1;
				end
			end
			S_ISSUE: st_next = S_WAIT;
			default: if (cyc.done) begin
				if (step.rd)
					rdata_next = cyc.rdata;
				if (step.last) begin
					st_next = S_IDLE;
				end else begin
					idx_next = idx_reg + 3'h1;
					st_next = S_ISSUE;
				end
			end
		endcase
		// A new order while busy is refused; set wins over clear
		if (ctrl_wr && st_reg != S_IDLE)
			refused_next = 1'b1;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_reg <= S_IDLE;
			op_reg <= OP_READ;
			idx_reg <= 3'h0;
			addr_reg <= 21'h000000;
			wdata_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
			refused_reg <= 1'b0;
			rb_s1_reg <= 1'b0;
			rb_s2_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			op_reg <= op_next;
			idx_reg <= idx_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
			refused_reg <= refused_next;
			rb_s1_reg <= flash_ready_busy_n;
			rb_s2_reg <= rb_s1_reg;
		end
	end

	assign cyc.start = st_reg == S_ISSUE;
	assign cyc.is_read = step.rd;
	assign cyc.addr = step.addr;
	assign cyc.wdata = step.data;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence unlock_s;
		cyc.start && idx_reg == 3'h0 && cyc.addr == UNLOCK1_ADDR && cyc.wdata == 16'h00aa;
	endsequence
	// Program words carry real data in the upper byte, so only they are exempt
	upper_byte_a: assert property (
		cyc.start && !step.rd && !(op_reg == OP_PROGRAM && idx_reg == 3'h3)
		&& !(op_reg == OP_BYP_PROGRAM && idx_reg == 3'h1) |-> cyc.wdata[15:8] == 8'h00)
		else $error("upper byte set on command write");
	unlock_first_a: assert property (
		cyc.start && idx_reg == 3'h0 && (op_reg == OP_PROGRAM || op_reg == OP_CHIP_ERASE)
		|-> unlock_s)
		else $error("long sequence did not open with unlock");
	sector_tail_a: assert property (
		cyc.start && op_reg == OP_SECTOR_ERASE && idx_reg == 3'h5
		|-> cyc.wdata == 16'h0030 && (cyc.addr & ~SECTOR_MASK) == 21'h0)
		else $error("sector erase tail wrong");
	autosel_read_a: assert property (
		cyc.start && op_reg == OP_AUTOSEL |-> cyc.is_read == (idx_reg == 3'h3))
		else $error("autoselect cycle direction wrong");
	refuse_busy_a: assert property (
		ctrl_wr && st_reg != S_IDLE |=> refused_reg && $stable(op_reg))
		else $error("order taken while busy");
	query_one_a: assert property (
		cyc.start && op_reg == OP_QUERY |-> cyc.addr == QUERY_ADDR && step.last
		##1 !cyc.start [*2])
		else $error("query not a single write");
	reset_single_a: assert property (
		cyc.start && op_reg == OP_RESET |-> cyc.wdata == 16'h00f0 ##1 st_reg == S_WAIT)
		else $error("reset write wrong");
	issue_done_a: assert property (cyc.done && step.last |=> st_reg == S_IDLE)
		else $error("sequence did not finish");
endmodule : flash_host_ctrl

/* File: sim/flash_model.sv */
/*
 * Behavioural x16 NOR flash: command decoder, status output, busy pin.
 * Assumes host strobes are active low and addresses are word addresses.
 */
`timescale 1ns/10ps
module flash_model #(
	parameter logic [15:0] MAKER_CODE = 16'h00a5, // arbitrary
	parameter logic [15:0] DEVICE_CODE = 16'h5a3c, // arbitrary
	parameter logic [15:0] QUERY_WORD = 16'h0051,
	parameter int PROG_T = 100,
	parameter int ERASE_T = 300
) (
	input wire logic [20:0] addr,
	input wire logic [15:0] dq_out,
	input wire logic dq_oe_n,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	output logic [15:0] dq_in,
	output logic ready_busy_n
);
	logic [15:0] mem [int];
	logic [36:0] wlog [$];
	int rcount = 0, step = 0, mode = 0, busy = 0;
	bit susp, erasing, prog, prog_next, exit_next, armed, tog;
	logic [20:0] la, prog_loc;
	logic [15:0] out = 16'h0000;
	wire wr_n = ce_n | we_n;
	wire rd_n = ce_n | oe_n;
	always @(negedge wr_n) la = addr;
	always @(posedge wr_n) wr(la, dq_out);
	// Only low byte and low address bits decode commands
	task automatic wr(input logic [20:0] ad, input logic [15:0] w);
		logic [7:0] d;
		logic [10:0] a;
		d = w[7:0];
		a = ad[10:0];
		wlog.push_back({ad, w});
		if (prog_next) begin
			mem[ad] = w;
			prog_loc = ad;
			prog = 1;
			busy = PROG_T;
			prog_next = 0;
		end else if (d == 8'hf0) begin
			mode = 0;
			step = 0;
			exit_next = 0;
		end else if (exit_next && d == 8'h00) begin
			mode = 0;
			exit_next = 0;
		end else if (mode == 4 && d == 8'ha0) prog_next = 1;
		else if (mode == 4 && d == 8'h90) exit_next = 1;
		else if (d == 8'hb0) begin
			if (erasing) susp = 1;
		end else if (step == 2 && armed) begin
			erasing = (d == 8'h30);
			busy = ERASE_T;
			step = 0;
			armed = 0;
		end else if (d == 8'h30 && susp) susp = 0;
		else if (a == 11'h055 && d == 8'h98 && mode < 2) mode = 2;
		else if (step == 0 && a == 11'h555 && d == 8'haa) step = 1;
		else if (step == 1 && a == 11'h2aa && d == 8'h55) step = 2;
		else if (step == 2 && a == 11'h555) begin
			step = 0;
			case (d)
				8'h90: if (mode == 3) exit_next = 1; else mode = 1;
				8'h88: mode = 3;
				8'ha0: prog_next = 1;
				8'h20: mode = 4;
				8'h80: armed = 1;
				default: ;
			endcase
		end else begin
			step = 0;
			armed = 0;
		end
	endtask : wr
	always #10 begin
		if (busy > 0 && !susp) busy--;
		if (busy == 0) {erasing, prog} = 2'b00;
	end
	assign ready_busy_n = (busy == 0) || susp;
	function automatic logic [15:0] rdval(input logic [20:0] a);
		if (busy > 0 && !susp)
			return {8'h00, prog ? ~mem[prog_loc][7] : 1'b0, tog, 6'h00};
		if (mode == 1) case (a[7:0])
			8'h00: return MAKER_CODE;
			8'h01: return DEVICE_CODE;
			8'h02: return {15'h0000, a[12]};
			8'h03: return 16'h008d;
			default: return 16'h0000;
		endcase
		if (mode == 2) return QUERY_WORD;
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction : rdval
	always @(negedge rd_n) begin
		rcount++;
		tog = ~tog;
		out = rdval(addr);
	end
	// Released bus shows the inverse so stale data cannot pass
	always @(posedge rd_n) out = ~out;
	assign dq_in = out;
endmodule : flash_model

/* File: sim/tb.sv */
/*
 * Self-checking bench for the flash host controller over APB.
 * Assumes the flash model sits on the flash pins, one 125 MHz clock.
 */
`timescale 1ns/10ps
module tb;
	import flash_host_pkg::*;
	logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, se;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, ce_n, we_n, oe_n, dq_oe_n, rb_n;
	wire logic [20:0] fa;
	wire logic [15:0] dqo, dqi;
	int mismatches = 0, checks = 0;
	logic [20:0] ea [$], al [5], tgt_a, pb;
	logic [15:0] ed [$], pw, pwb;
	bit ec [$];
	always #4 clock = ~clock;
	flash_host_ctrl DUT (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_addr(fa), .flash_dq_out(dqo), .flash_dq_oe_n(dq_oe_n),
		.flash_dq_in(dqi), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
		.flash_ready_busy_n(rb_n));
	flash_model fm (.addr(fa), .dq_out(dqo), .dq_oe_n(dq_oe_n), .ce_n(ce_n), .we_n(we_n),
		.oe_n(oe_n), .dq_in(dqi), .ready_busy_n(rb_n));
	task end_of_test;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	// Entered just after a rising edge; data taken at the pready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		se = pslverr;
		if (pready !== 1'b1) begin
			mismatches++;
			end_of_test;
		end
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask : apb
	task poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(0, REG_STATUS, 32'h0);
			n++;
		end while (rd[b] !== v && n < 2000);
		if (rd[b] !== v) begin
			mismatches++;
			end_of_test;
		end
	endtask : poll
	task push(input bit c, input logic [20:0] a, input logic [15:0] d);
		ec.push_back(c);
		ea.push_back(a);
		ed.push_back(d);
	endtask : push
	task exp_seq(input logic [3:0] op, input logic [20:0] a, input logic [15:0] w);
		ec.delete();
		ea.delete();
		ed.delete();
		if (op inside {2, 4, 5, 6, 7, 10, 11}) begin
			push(1, 21'h555, 16'haa);
			push(1, 21'h2aa, 16'h55);
		end
		case (op)
			1: push(0, 0, 16'hf0);
			2: push(1, 21'h555, 16'h90);
			3: push(1, 21'h55, 16'h98);
			4: push(1, 21'h555, 16'h88);
			5: begin push(1, 21'h555, 16'h90); push(0, 0, 16'h00); end
			6: begin push(1, 21'h555, 16'ha0); push(1, a, w); end
			7: push(1, 21'h555, 16'h20);
			8: begin push(0, 0, 16'ha0); push(1, a, w); end
			9: begin push(0, 0, 16'h90); push(0, 0, 16'h00); end
			10, 11: begin
				push(1, 21'h555, 16'h80);
				push(1, 21'h555, 16'haa);
				push(1, 21'h2aa, 16'h55);
				if (op == 10) push(1, 21'h555, 16'h10);
				else push(1, a & 21'h0ff000, 16'h30);
			end
			12: push(0, 0, 16'hb0);
			13: push(0, 0, 16'h30);
			default: ;
		endcase
	endtask : exp_seq
	task run_op(input logic [3:0] op, input logic [20:0] a, input logic [15:0] w);
		int n0, r0;
		n0 = fm.wlog.size();
		r0 = fm.rcount;
		apb(1, REG_ADDR, {11'h0, a});
		apb(1, REG_WDATA, {16'h0, w});
		apb(1, REG_CTRL, {28'h0, op});
		poll(ST_BUSY, 0);
		exp_seq(op, a, w);
		check(32'(fm.wlog.size() - n0), 32'(ed.size()));
		for (int i = 0; i < ed.size() && n0 + i < fm.wlog.size(); i++) begin
			check(32'(fm.wlog[n0 + i][15:0]), 32'(ed[i]));
			if (ec[i]) check(32'(fm.wlog[n0 + i][36:16]), 32'(ea[i]));
		end
		check(32'(fm.rcount - r0), 32'(op == 0 || op == 2));
	endtask : run_op
	task read_at(input logic [20:0] a, input logic [31:0] e);
		run_op(0, a, 16'h0);
		apb(0, REG_RDATA, 32'h0);
		check(rd, e);
	endtask : read_at
	initial begin
		void'($urandom(32'h7b86cc43));
		tgt_a = {1'b0, 20'($urandom)} | 21'h001000;
		pb = {1'b0, 20'($urandom)} & 21'h0fefff;
		pw = 16'($urandom);
		pwb = 16'($urandom);
		al = '{21'h0, 21'h1, 21'h3, 21'h1a3002, 21'h0a2002};
		repeat (3) @(posedge clock);
		resetn <= 1;
		@(posedge clock);
		apb(0, REG_STATUS, 32'h0);
		check(rd, 32'h2);
		read_at(tgt_a, 32'hffff);
		foreach (al[i]) begin
			run_op(2, al[i], 16'h0);
			apb(0, REG_RDATA, 32'h0);
			check(rd, i == 0 ? 32'h00a5 : i == 1 ? 32'h5a3c : i == 2 ? 32'h8d : i == 3);
		end
		run_op(1, 0, 16'h0);
		read_at(tgt_a, 32'hffff);
		run_op(3, 0, 16'h0);
		read_at(21'h10, 32'h0051);
		run_op(1, 0, 16'h0);
		run_op(4, 0, 16'h0);
		run_op(5, 0, 16'h0);
		run_op(6, tgt_a, pw);
		run_op(0, tgt_a, 16'h0);
		apb(0, REG_RDATA, 32'h0);
		// Concatenation keeps the inversion one bit wide
		check(rd[7], {31'h0, ~pw[7]});
		apb(0, REG_STATUS, 32'h0);
		check(rd[1], 0);
		poll(ST_READY, 1);
		read_at(tgt_a, {16'h0, pw});
		run_op(7, 0, 16'h0);
		run_op(8, pb, pwb);
		poll(ST_READY, 1);
		run_op(9, 0, 16'h0);
		read_at(pb, {16'h0, pwb});
		apb(1, REG_CTRL, 32'h1);
		apb(1, REG_CTRL, 32'h1);
		poll(ST_BUSY, 0);
		check(rd[2], 1);
		apb(1, REG_STATUS, 32'h4);
		apb(1, REG_CTRL, 32'hf);
		apb(0, REG_STATUS, 32'h0);
		check(rd[2], 1);
		apb(1, 8'h20, 32'h1);
		check(se, 1);
		run_op(11, tgt_a, 16'h0);
		check(rd[1], 0);
		run_op(12, 0, 16'h0);
		repeat (2) apb(0, REG_STATUS, 32'h0);
		check(rd[1], 1);
		read_at(pb, {16'h0, pwb});
		run_op(13, 0, 16'h0);
		repeat (2) apb(0, REG_STATUS, 32'h0);
		check(rd[1], 0);
		poll(ST_READY, 1);
		run_op(10, 0, 16'h0);
		run_op(12, 0, 16'h0);
		repeat (2) apb(0, REG_STATUS, 32'h0);
		check(rd[1], 0);
		poll(ST_READY, 1);
		end_of_test;
	end
endmodule : tb
